// ==== src/aca_pkg.sv ====
// Purpose: Shared constants for the monitor converter control block
// Assumes: Registers reached over AXI4-Lite, byte address = 4 * index
// Notes: Indices kept as printed; the average register index is local
package aca_pkg;
   // Register indices, byte address is index times four
   localparam logic [9:0] IDX_RES_BASE = 10'h01A;
   localparam logic [9:0] IDX_RES_LAST = 10'h021;
   localparam logic [9:0] IDX_CTRL = 10'h022;
   localparam logic [9:0] IDX_AVG = 10'h030;
   // Result block slots relative to the base
   localparam logic [2:0] SLOT_A_HI = 3'h0;
   localparam logic [2:0] SLOT_A_LO = 3'h1;
   localparam logic [2:0] SLOT_B_HI = 3'h2;
   localparam logic [2:0] SLOT_B_LO = 3'h3;
   // Control register fields
   localparam int CTRL_START_A = 0;
   localparam int CTRL_MUX_A = 1;
   localparam int CTRL_REF_A = 2;
   localparam int CTRL_START_B = 3;
   localparam int CTRL_REF_B = 5;
   localparam int CTRL_SIDE_SEL = 6;
   localparam int CTRL_SIDE_EN = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Average register fields
   localparam int AVG_CODE_LSB = 0;
   localparam int AVG_BUSY_A = 4;
   localparam int AVG_BUSY_B = 5;
   localparam int AVG_START_B = 6;
   localparam int AVG_START_A = 7;
   localparam logic [2:0] AVG_CODE_RST = 3'h0;
   localparam logic [2:0] AVG_CODE_MAX = 3'h6;
   // Widths and AXI response codes
   localparam int RES_W = 10;
   localparam int ACC_W = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : aca_pkg

// ==== src/aca_avg_if.sv ====
// Purpose: Request and answer between control and one averaging engine
// Assumes: Single clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
interface aca_avg_if;
   logic start;
   logic [2:0] log2n;
   logic busy;
   logic done;
   logic [9:0] result;
   modport avg (input start, input log2n, output busy, output done,
      output result);
   modport ctl (output start, output log2n, input busy, input done,
      input result);
endinterface : aca_avg_if

// ==== src/aca_averager.sv ====
// Purpose: Runs 2**n conversions on one converter and averages them
// Assumes: Converter answers with a done pulse at least a cycle later
// Notes: Start while busy is ignored by the caller
`timescale 1ns/1ps
module aca_averager (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Request side
   aca_avg_if.avg av,
   // Converter side
   output logic o_conv_start,
   input wire logic i_conv_done,
   input wire logic [9:0] i_conv_data
);
   typedef enum logic {ST_IDLE, ST_CONV} aca_avg_st_t;
   aca_avg_st_t st_q;
   logic [2:0] n_q;
   logic [5:0] cnt_q;
   logic [15:0] acc_q;
   logic [15:0] sum;
   logic [5:0] last;

   // Running sum including the sample arriving now
   assign sum = acc_q + {6'h00, i_conv_data};
   assign last = 6'(({5'h00, 1'b1} << n_q) - 6'h01);
   assign av.busy = (st_q != ST_IDLE);

   // Sequencer: one conversion at a time, sum them, shift to average
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= ST_IDLE;
         n_q <= 3'h0;
         cnt_q <= 6'h00;
         acc_q <= 16'h0000;
         o_conv_start <= 1'b0;
         av.done <= 1'b0;
         av.result <= 10'h000;
      end else begin
         o_conv_start <= 1'b0;
         av.done <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (av.start) begin
                  n_q <= av.log2n;
                  cnt_q <= 6'h00;
                  acc_q <= 16'h0000;
                  o_conv_start <= 1'b1;
                  st_q <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (i_conv_done) begin
                  if (cnt_q == last) begin
                     // Whole 10 bits land at once, halves never mix
                     av.result <= 10'(sum >> n_q);
                     av.done <= 1'b1;
                     st_q <= ST_IDLE;
                  end else begin
                     acc_q <= sum;
                     cnt_q <= cnt_q + 6'h01;
                     o_conv_start <= 1'b1;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule : aca_averager

// ==== src/aca_top.sv ====
// Purpose: Control and result registers for two monitor converters
// Assumes: Converters sit on the same clock; side port start is a pin
// Notes: AXI4-Lite slave, one write and one read in flight at most
// Functional notes
// - Results read-only, 10-bit offset binary, writes ignored
// - Upper eight bits and lower two split
// - Control bit 7 enables side serial port
// - Control bit 6 picks side port converter
// - Bits 5 and 2 pick internal reference
// - Bit 1 high routes first input to A
// - Bits 3 and 0 one-shot starts, read zero
// - Start-average runs 2**n conversions, stores average
`timescale 1ns/1ps
module aca_top (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // AXI4-Lite write
   input wire logic [11:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read
   input wire logic [11:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Converters, index 0 is A, 1 is B
   output logic [1:0] o_conv_start,
   input wire logic [1:0] i_conv_done,
   input wire logic [19:0] i_conv_data,
   output logic o_ref_int_a,
   output logic o_ref_int_b,
   output logic o_mux_first_a,
   // Side serial port
   input wire logic i_side_start,
   output logic o_side_port_en,
   output logic [9:0] o_side_result
);
   logic [7:0] ctrl_q;
   logic [2:0] code_q;
   logic [1:0] start_q;
   logic [2:0] start_n_q;
   logic [19:0] res_q;
   logic [2:0] side_sync_q;
   logic wr_go;
   logic rd_go;
   logic wr_ok;
   logic [9:0] wr_idx;
   logic [9:0] rd_idx;
   logic [2:0] slot;
   logic [1:0] busy;
   logic side_edge;

   // Handshake takes and register index decode
   assign wr_go = o_awready && i_awvalid && i_wvalid;
   assign rd_go = o_arready && i_arvalid;
   assign wr_idx = i_awaddr[11:2];
   assign rd_idx = i_araddr[11:2];
   assign slot = 3'(rd_idx - aca_pkg::IDX_RES_BASE);
   assign wr_ok = (wr_idx == aca_pkg::IDX_CTRL) ||
      (wr_idx == aca_pkg::IDX_AVG) ||
      (wr_idx >= aca_pkg::IDX_RES_BASE && wr_idx <= aca_pkg::IDX_RES_LAST);
   // Second stage only feeds the edge flop, never the first
   assign side_edge = side_sync_q[1] && !side_sync_q[2];

   // Write channel: take address and data together, then respond
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= aca_pkg::RESP_OKAY;
      end else begin
         o_awready <= i_awvalid && i_wvalid && !o_awready && !o_bvalid;
         o_wready <= i_awvalid && i_wvalid && !o_awready && !o_bvalid;
         if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? aca_pkg::RESP_OKAY : aca_pkg::RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // Control register; start bits never stored, so they read zero
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_q <= aca_pkg::CTRL_RST;
         code_q <= aca_pkg::AVG_CODE_RST;
      end else if (wr_go && i_wstrb[0]) begin
         if (wr_idx == aca_pkg::IDX_CTRL) begin
            ctrl_q <= i_wdata[7:0];
            ctrl_q[aca_pkg::CTRL_START_A] <= 1'b0;
            ctrl_q[aca_pkg::CTRL_START_B] <= 1'b0;
            ctrl_q[4] <= 1'b0;
         end else if (wr_idx == aca_pkg::IDX_AVG) begin
            // Unused code 7 would overflow the counter, clamp it
            code_q <= (i_wdata[2:0] > aca_pkg::AVG_CODE_MAX) ?
               aca_pkg::AVG_CODE_MAX : i_wdata[2:0];
         end
      end
   end

   // Side port pin: two-flop sync then edge detect
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         side_sync_q <= 3'h0;
      end else begin
         side_sync_q <= {side_sync_q[1:0], i_side_start};
      end
   end

   // Start requests from software and from the side port
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         start_q <= 2'h0;
         start_n_q <= 3'h0;
      end else begin
         start_q <= 2'h0;
         start_n_q <= 3'h0;
         if (wr_go && i_wstrb[0] && wr_idx == aca_pkg::IDX_CTRL) begin
            start_q[0] <= i_wdata[aca_pkg::CTRL_START_A];
            start_q[1] <= i_wdata[aca_pkg::CTRL_START_B];
         end else if (wr_go && i_wstrb[0] && wr_idx == aca_pkg::IDX_AVG) begin
            start_q[0] <= i_wdata[aca_pkg::AVG_START_A];
            start_q[1] <= i_wdata[aca_pkg::AVG_START_B];
            start_n_q <= i_wdata[aca_pkg::AVG_CODE_LSB +: 3] >
               aca_pkg::AVG_CODE_MAX ? aca_pkg::AVG_CODE_MAX :
               i_wdata[aca_pkg::AVG_CODE_LSB +: 3];
         end else if (side_edge && ctrl_q[aca_pkg::CTRL_SIDE_EN]) begin
            // Side port serves A when select is low, else B
            start_q[ctrl_q[aca_pkg::CTRL_SIDE_SEL]] <= 1'b1;
         end
      end
   end

   // One averaging engine per converter
   generate
      for (genvar g = 0; g < 2; g++) begin : g_conv
         aca_avg_if av ();
         assign av.start = start_q[g] && !av.busy;
         assign av.log2n = start_n_q;
         assign busy[g] = av.busy;
         aca_averager u_avg (
            .i_clk_sys(i_clk_sys),
            .i_rst_b(i_rst_b),
            .av(av.avg),
            .o_conv_start(o_conv_start[g]),
            .i_conv_done(i_conv_done[g]),
            .i_conv_data(i_conv_data[g*10 +: 10])
         );
         // Result latched whole when the engine finishes
         always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
            if (!i_rst_b) begin
               res_q[g*10 +: 10] <= 10'h000;
            end else if (av.done) begin
               res_q[g*10 +: 10] <= av.result;
            end
         end
      end
   endgenerate

   // Analog steering and side port outputs
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_ref_int_a <= 1'b0;
         o_ref_int_b <= 1'b0;
         o_mux_first_a <= 1'b0;
         o_side_port_en <= 1'b0;
         o_side_result <= 10'h000;
      end else begin
         o_ref_int_a <= ctrl_q[aca_pkg::CTRL_REF_A];
         o_ref_int_b <= ctrl_q[aca_pkg::CTRL_REF_B];
         o_mux_first_a <= ctrl_q[aca_pkg::CTRL_MUX_A];
         o_side_port_en <= ctrl_q[aca_pkg::CTRL_SIDE_EN];
         o_side_result <= ctrl_q[aca_pkg::CTRL_SIDE_SEL] ?
            res_q[19:10] : res_q[9:0];
      end
   end

   // Read channel: data one cycle after the address is taken
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= aca_pkg::RESP_OKAY;
      end else begin
         o_arready <= i_arvalid && !o_arready && !o_rvalid;
         if (rd_go) begin
            o_rvalid <= 1'b1;
            o_rresp <= aca_pkg::RESP_OKAY;
            o_rdata <= 32'h00000000;
            if (rd_idx == aca_pkg::IDX_CTRL) begin
               o_rdata[7:0] <= ctrl_q;
            end else if (rd_idx == aca_pkg::IDX_AVG) begin
               o_rdata[2:0] <= code_q;
               o_rdata[aca_pkg::AVG_BUSY_A] <= busy[0];
               o_rdata[aca_pkg::AVG_BUSY_B] <= busy[1];
            end else if (rd_idx >= aca_pkg::IDX_RES_BASE &&
                         rd_idx <= aca_pkg::IDX_RES_LAST) begin
               case (slot)
                  aca_pkg::SLOT_A_HI: o_rdata[7:0] <= res_q[9:2];
                  aca_pkg::SLOT_A_LO: o_rdata[1:0] <= res_q[1:0];
                  aca_pkg::SLOT_B_HI: o_rdata[7:0] <= res_q[19:12];
                  aca_pkg::SLOT_B_LO: o_rdata[1:0] <= res_q[11:10];
                  default: o_rdata[7:0] <= 8'h00;
               endcase
            end else begin
               o_rresp <= aca_pkg::RESP_SLVERR;
            end
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   a_start_oneshot: assert property (
      !ctrl_q[aca_pkg::CTRL_START_A] && !ctrl_q[aca_pkg::CTRL_START_B])
      else $error("start bit stored in control");
   a_start_a_conv: assert property (
      start_q[0] && !busy[0] |-> ##1 o_conv_start[0])
      else $error("start A did not reach converter");
   a_result_ro: assert property (
      wr_go && wr_idx == aca_pkg::IDX_RES_BASE && !g_conv[0].av.done
      |=> $stable(res_q[9:0]))
      else $error("result changed on write");
   a_side_route: assert property (
      side_edge && ctrl_q[aca_pkg::CTRL_SIDE_EN] &&
      ctrl_q[aca_pkg::CTRL_SIDE_SEL] && !(wr_go && i_wstrb[0] &&
      (wr_idx == aca_pkg::IDX_CTRL || wr_idx == aca_pkg::IDX_AVG))
      |=> start_q[1] && !start_q[0])
      else $error("side port start misrouted");
   a_side_off: assert property (
      !ctrl_q[aca_pkg::CTRL_SIDE_EN] && !wr_go |=> start_q == 2'h0)
      else $error("start while side port disabled");
   a_ref_follow: assert property (
      ##1 o_ref_int_b == $past(ctrl_q[aca_pkg::CTRL_REF_B]) &&
      o_ref_int_a == $past(ctrl_q[aca_pkg::CTRL_REF_A]))
      else $error("reference select wrong");
   a_mux_follow: assert property (
      ##1 o_mux_first_a == $past(ctrl_q[aca_pkg::CTRL_MUX_A]))
      else $error("input mux wrong");
   a_pair_atomic: assert property (
      !g_conv[1].av.done |=> $stable(res_q[19:10]))
      else $error("B result changed without done");
   // Converter data is only good on its done edge, one edge before latch, two before the check
   a_avg_single: assert property (
      g_conv[0].av.done && g_conv[0].u_avg.n_q == 3'h0
      |=> res_q[9:0] == $past(i_conv_data[9:0], 2))
      else $error("single conversion result wrong");
   c_write: cover property (wr_go);
   c_side: cover property (side_edge && ctrl_q[7]);
   c_avg_done: cover property (g_conv[1].av.done);
endmodule : aca_top

// ==== test/aca_conv_model.sv ====
// Purpose: Behavioural pair of monitor converters facing the block
// Assumes: Same clock as the block, latency of at least one cycle
// Notes: Data away from the done pulse toggles, so stale reads show up
`timescale 1ns/1ps
module aca_conv_model (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Requests and settings
   input wire logic [1:0] i_start,
   input wire logic [19:0] i_value,
   input wire logic [7:0] i_lat,
   // Answers
   output logic [1:0] o_done,
   output logic [19:0] o_data
);
   for (genvar k = 0; k < 2; k++) begin : g_conv
      logic [7:0] cnt_q;
      logic done_q;
      logic [9:0] data_q;
      assign o_done[k] = done_q;
      assign o_data[k*10 +: 10] = data_q;
      // Countdown per converter; a start while busy is dropped
      always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
         if (!i_rst_b) begin
            cnt_q <= 8'h00;
            done_q <= 1'b0;
            data_q <= 10'h000;
         end else begin
            done_q <= (cnt_q == 8'h01);
            if (cnt_q == 8'h01) begin
               data_q <= i_value[k*10 +: 10];
            end else begin
               data_q <= ~data_q;
            end
            if (cnt_q != 8'h00) begin
               cnt_q <= cnt_q - 8'h01;
            end else if (i_start[k]) begin
               cnt_q <= i_lat;
            end
         end
      end
   end
endmodule : aca_conv_model

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the monitor converter control block
// Assumes: AXI4-Lite master here, converter pair from the partner model
// Notes: Reads queue their expected word; a monitor compares on rvalid
`timescale 1ns/1ps
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   logic [11:0] i_awaddr = 12'h000;
   logic [11:0] i_araddr = 12'h000;
   logic [31:0] i_wdata = 32'h00000000;
   logic i_awvalid = 1'b0;
   logic i_wvalid = 1'b0;
   logic i_bready = 1'b0;
   logic i_arvalid = 1'b0;
   logic i_rready = 1'b0;
   logic i_side_start = 1'b0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic o_ref_int_a, o_ref_int_b, o_mux_first_a, o_side_port_en;
   logic [1:0] o_bresp, o_rresp, o_conv_start, i_conv_done;
   logic [31:0] o_rdata;
   logic [19:0] i_conv_data;
   logic [9:0] o_side_result;
   logic [19:0] cval = 20'h00000;
   logic [7:0] lat = 8'h01;
   logic [19:0] v = 20'h00000;
   logic [31:0] lfsr_q = 32'hB1B4EB6B;
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   int n_fail = 0;
   int cmp_count = 0;
   localparam logic [11:0] A_CTRL = {aca_pkg::IDX_CTRL, 2'h0};
   localparam logic [11:0] A_RES = {aca_pkg::IDX_RES_BASE, 2'h0};
   localparam logic [11:0] A_AVG = {aca_pkg::IDX_AVG, 2'h0};
   localparam logic [1:0] OK = aca_pkg::RESP_OKAY;

   // Clock at 200 MHz
   always #2.5 i_clk_sys = ~i_clk_sys;

   aca_top dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_wdata(i_wdata), .i_wstrb(4'hF), .i_wvalid(i_wvalid),
      .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
      .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .o_rvalid(o_rvalid), .i_rready(i_rready),
      .o_conv_start(o_conv_start), .i_conv_done(i_conv_done),
      .i_conv_data(i_conv_data), .o_ref_int_a(o_ref_int_a),
      .o_ref_int_b(o_ref_int_b), .o_mux_first_a(o_mux_first_a),
      .i_side_start(i_side_start), .o_side_port_en(o_side_port_en),
      .o_side_result(o_side_result));

   aca_conv_model u_conv (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .i_start(o_conv_start), .i_value(cval), .i_lat(lat),
      .o_done(i_conv_done), .o_data(i_conv_data));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // Bounded wait on one slave answer, values seen before the edge
   task automatic await(input int w);
      int t;
      logic s;
      t = 0;
      s = 1'b0;
      while (s !== 1'b1) begin
         @(posedge i_clk_sys);
         s = (w == 0) ? o_awready : (w == 1) ? o_bvalid :
            (w == 2) ? o_arready : o_rvalid;
         t++;
         if (t > 200) begin
            n_fail++;
            tally_and_finish();
         end
      end
   endtask : await

   task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] r);
      bq.push_back(r);
      i_awaddr <= a;
      i_wdata <= {24'h000000, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      await(0);
      i_awvalid <= 1'b0;
      i_wvalid <= 1'b0;
      i_bready <= 1'b1;
      await(1);
      i_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] r);
      rq.push_back({r, 24'h000000, d});
      i_araddr <= a;
      i_arvalid <= 1'b1;
      await(2);
      i_arvalid <= 1'b0;
      i_rready <= 1'b1;
      await(3);
      i_rready <= 1'b0;
   endtask : rd

   // Count n done pulses of converter k, then let the result latch
   task automatic conv(input int k, input int n);
      int t;
      int c;
      t = 0;
      c = 0;
      while (c < n) begin
         @(posedge i_clk_sys);
         if (i_conv_done[k] === 1'b1) c++;
         t++;
         if (t > 2000) begin
            n_fail++;
            tally_and_finish();
         end
      end
      repeat (3) @(posedge i_clk_sys);
   endtask : conv

   // Monitor takes the oldest note whenever an answer is handed over
   always @(posedge i_clk_sys) begin
      if (o_rvalid === 1'b1 && i_rready) begin
         check({o_rresp, o_rdata}, rq.pop_front());
      end
      if (o_bvalid === 1'b1 && i_bready) begin
         check({32'h00000000, o_bresp}, {32'h00000000, bq.pop_front()});
      end
   end

   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      @(posedge i_clk_sys);
      rd(A_CTRL, 8'h00, OK);
      rd(12'h100, 8'h00, aca_pkg::RESP_SLVERR);
      wr(12'h100, 8'hFF, aca_pkg::RESP_SLVERR);
      // Steering fields reach the pins and read back
      wr(A_CTRL, 8'h26, OK);
      repeat (2) @(posedge i_clk_sys);
      check({30'h0, o_side_port_en, o_ref_int_b, o_ref_int_a,
         o_mux_first_a}, 34'h7);
      rd(A_CTRL, 8'h26, OK);
      wr(A_CTRL, 8'h00, OK);
      repeat (2) @(posedge i_clk_sys);
      check({30'h0, o_ref_int_b, o_ref_int_a, o_mux_first_a,
         o_side_port_en}, 34'h0);
      $display("test steering done");
      // One conversion each, prompt then slow converter
      for (int k = 0; k < 2; k++) begin
         lfsr_q = lfsr(lfsr_q);
         v[k*10 +: 10] = lfsr_q[9:0];
         cval <= v;
         lat <= (k == 0) ? 8'h01 : 8'h14;
         wr(A_CTRL, (k == 0) ? 8'h01 : 8'h08, OK);
         conv(k, 1);
         rd(A_RES + 12'(8 * k), v[k*10+2 +: 8], OK);
         rd(A_RES + 12'(8 * k + 4), {6'h00, v[k*10 +: 2]}, OK);
         rd(A_CTRL, 8'h00, OK);
      end
      wr(A_RES, 8'hFF, OK);
      rd(A_RES, v[9:2], OK);
      rd(A_RES + 12'h010, 8'h00, OK);
      $display("test conversion done");
      // Side port serves A, then B, then starts B from its pin
      wr(A_CTRL, 8'h80, OK);
      repeat (3) @(posedge i_clk_sys);
      check({23'h0, o_side_port_en, o_side_result}, {24'h1, v[9:0]});
      wr(A_CTRL, 8'hC0, OK);
      repeat (3) @(posedge i_clk_sys);
      check({24'h0, o_side_result}, {24'h0, v[19:10]});
      lfsr_q = lfsr(lfsr_q);
      v[19:10] = lfsr_q[9:0];
      cval <= v;
      i_side_start <= 1'b1;
      conv(1, 1);
      i_side_start <= 1'b0;
      rd(A_RES + 12'h008, v[19:12], OK);
      $display("test side port done");
      // Average of four equal samples on A
      lfsr_q = lfsr(lfsr_q);
      v[9:0] = lfsr_q[9:0];
      cval <= v;
      wr(A_AVG, 8'h82, OK);
      conv(0, 4);
      rd(A_RES, v[9:2], OK);
      rd(A_RES + 12'h004, {6'h00, v[1:0]}, OK);
      rd(A_AVG, 8'h02, OK);
      // Unused sample code clamps to the largest count
      wr(A_AVG, 8'h07, OK);
      rd(A_AVG, 8'h06, OK);
      $display("test average done");
      // Mid-run reset puts settings and results back to zero
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      @(posedge i_clk_sys);
      check({23'h0, o_side_port_en, o_side_result}, 34'h0);
      rd(A_CTRL, 8'h00, OK);
      rd(A_RES + 12'h008, 8'h00, OK);
      $display("test reset done");
      tally_and_finish();
   end
endmodule : tb_top
